/* dfw_monitor.v */
`timescale 1ns/10ps
`include "dfw_defines.vh"
// drive fault and warning supervisor with status display coding
module dfw_monitor #(
    parameter TW = 16, // temperature width
    parameter VW = 16, // regen power width
    parameter CW = 16, // current width
    parameter SECOND_CYCLES = `DFW_SECOND_CYCLES,
    parameter BRAKE_FITTED = 1
) (
    clk,
    rstn,
    fault_code, // present fault number from fault detectors, 0 = none
    logic_present, // logic supply present
    hv_present, // high voltage present
    softstart_done, // high power section out of soft-start
    hw_enable, // hardware enable condition
    enable_req, // pin: operator enable request level
    bridge_temp,
    bridge_temp_max,
    motor_temp,
    motor_temp_max,
    ambient_temp,
    ambient_temp_max,
    regen_power,
    regen_power_max,
    position_mode,
    position_error_over, // position error beyond threshold
    limit_cw, // pin: clockwise limit switch
    limit_ccw, // pin: counter-clockwise limit switch
    supply_mv, // logic supply reading in millivolts
    manual_mode,
    manual_pct, // manual-mode cap in percent
    current_limit_nom,
    velocity_limit_nom,
    bridge_foldback, // bridge temperature foldback active
    motor_foldback,
    ambient_foldback,
    version_mismatch, // firmware and fieldbus card disagree
    demand_abs, // absolute current demand before thermal limiting
    i2t_limit,
    it_integral, // integral current demand
    it_max, // maximum current-time product
    eti_total_seed,
    eti_downs_seed,
    eti_enabled_seed,
    eti_seed_load,
    power_stage_on, // amplifier power allowed
    brake_request,
    drive_enabled,
    current_limited, // limiting indication
    current_limit, // applied current limit
    velocity_limit, // applied velocity limit
    block_cw,
    block_ccw,
    warnings, // bit n-1 = warning Un
    display_kind,
    display_code,
    elapsed_time_indicator_total_power_on_time,
    elapsed_time_indicator_power_on_time_since_power_on,
    elapsed_time_indicator_number_of_power_downs,
    elapsed_time_indicator_enabled_time,
    elapsed_time_indicator_enabled_time_since_power_on,
    elapsed_time_indicator_enabled_time_since_enable
);
    input wire clk;
    input wire rstn;
    input wire [4:0] fault_code;
    input wire logic_present;
    input wire hv_present;
    input wire softstart_done;
    input wire hw_enable;
    input wire enable_req;
    input wire [TW-1:0] bridge_temp;
    input wire [TW-1:0] bridge_temp_max;
    input wire [TW-1:0] motor_temp;
    input wire [TW-1:0] motor_temp_max;
    input wire [TW-1:0] ambient_temp;
    input wire [TW-1:0] ambient_temp_max;
    input wire [VW-1:0] regen_power;
    input wire [VW-1:0] regen_power_max;
    input wire position_mode;
    input wire position_error_over;
    input wire limit_cw;
    input wire limit_ccw;
    input wire [15:0] supply_mv;
    input wire manual_mode;
    input wire [6:0] manual_pct;
    input wire [CW-1:0] current_limit_nom;
    input wire [CW-1:0] velocity_limit_nom;
    input wire bridge_foldback;
    input wire motor_foldback;
    input wire ambient_foldback;
    input wire version_mismatch;
    input wire [CW-1:0] demand_abs;
    input wire [CW-1:0] i2t_limit;
    input wire [31:0] it_integral;
    input wire [31:0] it_max;
    input wire [31:0] eti_total_seed;
    input wire [31:0] eti_downs_seed;
    input wire [31:0] eti_enabled_seed;
    input wire eti_seed_load;
    output reg power_stage_on;
    output reg brake_request;
    output reg drive_enabled;
    output reg current_limited;
    output reg [CW-1:0] current_limit;
    output reg [CW-1:0] velocity_limit;
    output reg block_cw;
    output reg block_ccw;
    output reg [`DFW_NUM_WARN-1:0] warnings;
    output reg [1:0] display_kind;
    output reg [4:0] display_code;
    output wire [31:0] elapsed_time_indicator_total_power_on_time;
    output wire [31:0] elapsed_time_indicator_power_on_time_since_power_on;
    output wire [31:0] elapsed_time_indicator_number_of_power_downs;
    output wire [31:0] elapsed_time_indicator_enabled_time;
    output wire [31:0] elapsed_time_indicator_enabled_time_since_power_on;
    output wire [31:0] elapsed_time_indicator_enabled_time_since_enable;

    // three-stage synchronisers for the pin inputs
    reg [2:0] sy_en;
    reg [2:0] sy_cw;
    reg [2:0] sy_ccw;
    reg en_s; // filtered enable request
    reg cw_s; // filtered clockwise limit
    reg ccw_s; // filtered counter-clockwise limit
    reg en_s_d; // previous request, for the rising edge
    wire near_motor;
    wire near_bridge;
    wire near_ambient;
    wire near_regen;
    wire fault; // any fault present
    wire enable_ok; // every enable condition true
    wire engage_attempt; // fresh enable request edge
    reg attempt_latch; // latched failed enable attempt
    reg [`DFW_NUM_WARN-1:0] next_warnings;
    wire thermal_lim; // any current-reducing warning
    reg [4:0] next_code;
    reg [1:0] next_kind;
    wire [CW+6:0] cur_cap_p; // scaled current for manual mode
    wire [CW+6:0] vel_cap_p;
    integer i;

    // shared near-limit comparators
    dfw_near_limit #(.W(TW)) u_nm (.value(motor_temp), .max_value(motor_temp_max), .near(near_motor));
    dfw_near_limit #(.W(TW)) u_nb (.value(bridge_temp), .max_value(bridge_temp_max), .near(near_bridge));
    dfw_near_limit #(.W(TW)) u_na (.value(ambient_temp), .max_value(ambient_temp_max), .near(near_ambient));
    dfw_near_limit #(.W(VW)) u_nr (.value(regen_power), .max_value(regen_power_max), .near(near_regen));

    // pin sync; a change counts when stages two and three agree
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sy_en <= 3'h0;
            sy_cw <= 3'h0;
            sy_ccw <= 3'h0;
            en_s <= 1'b0;
            cw_s <= 1'b0;
            ccw_s <= 1'b0;
            en_s_d <= 1'b0;
        end
        else
        begin
            sy_en <= {sy_en[1:0], enable_req};
            sy_cw <= {sy_cw[1:0], limit_cw};
            sy_ccw <= {sy_ccw[1:0], limit_ccw};
            if (sy_en[1] == sy_en[2])
                en_s <= sy_en[2];
            if (sy_cw[1] == sy_cw[2])
                cw_s <= sy_cw[2];
            if (sy_ccw[1] == sy_ccw[2])
                ccw_s <= sy_ccw[2];
            en_s_d <= en_s;
        end
    end

    assign fault = (fault_code != 5'h0);
    // all enable conditions
    assign enable_ok = logic_present && hv_present && softstart_done && hw_enable && !version_mismatch;
    assign engage_attempt = en_s && !en_s_d;

    // warnings follow conditions, U9 held
    always @*
    begin
        next_warnings = {`DFW_NUM_WARN{1'b0}};
        next_warnings[0] = !softstart_done;
        next_warnings[1] = near_motor;
        next_warnings[2] = near_bridge;
        next_warnings[3] = near_regen;
        next_warnings[4] = position_mode && position_error_over;
        next_warnings[5] = cw_s || ccw_s;
        next_warnings[6] = (supply_mv < `DFW_SUPPLY_LOW_MV) || (supply_mv > `DFW_SUPPLY_HIGH_MV);
        next_warnings[7] = manual_mode;
        next_warnings[8] = attempt_latch;
        next_warnings[9] = bridge_foldback;
        next_warnings[10] = motor_foldback;
        next_warnings[11] = ambient_foldback;
        next_warnings[12] = near_ambient;
        next_warnings[13] = version_mismatch;
        next_warnings[16] = drive_enabled && (demand_abs >= i2t_limit);
        next_warnings[17] = it_integral > it_max;
    end

    // current reducing sources; U4..U7 do not reduce
    assign thermal_lim = next_warnings[1] | next_warnings[2] | next_warnings[9] | next_warnings[10]
        | next_warnings[11] | next_warnings[12] | next_warnings[16] | next_warnings[17];
    assign cur_cap_p = current_limit_nom * manual_pct / 7'h64;
    assign vel_cap_p = velocity_limit_nom * manual_pct / 7'h64;

    // display: fault, lowest warning, enabled, ready
    always @*
    begin
        next_kind = `DFW_KIND_READY;
        next_code = 5'h0;
        if (fault)
        begin
            next_kind = `DFW_KIND_FAULT;
            next_code = fault_code;
        end
        else if (next_warnings != {`DFW_NUM_WARN{1'b0}})
        begin
            next_kind = `DFW_KIND_WARN;
            // downward scan: lowest warning wins
            for (i = `DFW_NUM_WARN - 1; i >= 0; i = i - 1)
                if (next_warnings[i])
                    next_code = i[4:0] + 5'h1;
        end
        else if (drive_enabled)
        begin
            next_kind = `DFW_KIND_ENABLED;
            next_code = 5'h1;
        end
        else if (logic_present && hv_present)
        begin
            next_kind = `DFW_KIND_READY;
            next_code = 5'h0;
        end
    end

    // enable state, reactions and registered outputs
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            drive_enabled <= 1'b0;
            attempt_latch <= 1'b0;
            power_stage_on <= 1'b0;
            brake_request <= 1'b1;
            current_limited <= 1'b0;
            current_limit <= {CW{1'b0}};
            velocity_limit <= {CW{1'b0}};
            block_cw <= 1'b0;
            block_ccw <= 1'b0;
            warnings <= {`DFW_NUM_WARN{1'b0}};
            display_kind <= `DFW_KIND_READY;
            display_code <= 5'h0;
        end
        else
        begin
            if (fault)
                drive_enabled <= 1'b0;
            else if (!en_s || !enable_ok)
                drive_enabled <= 1'b0;
            else if (engage_attempt)
                drive_enabled <= 1'b1;
            // failed attempt sets, real enable clears; set wins
            if (engage_attempt && !fault && !enable_ok)
                attempt_latch <= 1'b1;
            else if (drive_enabled)
                attempt_latch <= 1'b0;
            power_stage_on <= !fault && drive_enabled;
            brake_request <= (BRAKE_FITTED != 0) && (fault || !drive_enabled);
            current_limited <= thermal_lim || manual_mode;
            if (manual_mode)
            begin
                current_limit <= cur_cap_p[CW-1:0];
                velocity_limit <= vel_cap_p[CW-1:0];
            end
            else
            begin
                // thermal and i2t reduction of the limit is done by the current loop
                current_limit <= current_limit_nom;
                velocity_limit <= velocity_limit_nom;
            end
            block_cw <= cw_s;
            block_ccw <= ccw_s;
            warnings <= next_warnings;
            display_kind <= next_kind;
            display_code <= next_code;
        end
    end

    dfw_elapsed_time #(.SECOND_CYCLES(SECOND_CYCLES), .W(32)) u_eti (
        .clk(clk),
        .rstn(rstn),
        .total_seed(eti_total_seed),
        .downs_seed(eti_downs_seed),
        .enabled_seed(eti_enabled_seed),
        .seed_load(eti_seed_load),
        .enabled(drive_enabled),
        .total_power_on_time(elapsed_time_indicator_total_power_on_time),
        .power_on_time_since_power_on(elapsed_time_indicator_power_on_time_since_power_on),
        .number_of_power_downs(elapsed_time_indicator_number_of_power_downs),
        .enabled_time(elapsed_time_indicator_enabled_time),
        .enabled_time_since_power_on(elapsed_time_indicator_enabled_time_since_power_on),
        .enabled_time_since_enable(elapsed_time_indicator_enabled_time_since_enable)
    );
endmodule // dfw_monitor

/* dfw_defines.vh */
`ifndef DFW_DEFINES_VH
`define DFW_DEFINES_VH
// display kinds
`define DFW_KIND_READY 2'h0
`define DFW_KIND_ENABLED 2'h1
`define DFW_KIND_WARN 2'h2
`define DFW_KIND_FAULT 2'h3
// logic supply window in millivolts
`define DFW_SUPPLY_LOW_MV 16'd18000
`define DFW_SUPPLY_HIGH_MV 16'd32000
// near-limit margin: within 10 percent means value*10 >= max*9
`define DFW_NEAR_NUM 8'd9
`define DFW_NEAR_DEN 8'd10
// one second tick at 100 MHz
`define DFW_CLK_HZ 100000000
`define DFW_SECOND_CYCLES (`DFW_CLK_HZ)
// number of warning slots, U1..U18
`define DFW_NUM_WARN 18
`endif

/* dfw_near_limit.v */
`timescale 1ns/10ps
`include "dfw_defines.vh"
// compares a reading with a maximum; high when within the top tenth
module dfw_near_limit #(
    parameter W = 16
) (
    value, // present reading
    max_value, // configured maximum
    near // reading is within ten percent of maximum
);
    input wire [W-1:0] value;
    input wire [W-1:0] max_value;
    output wire near;
    // widened products so neither side overflows
    wire [W+7:0] lhs;
    wire [W+7:0] rhs;
    // cross-multiply instead of dividing, cheap and exact
    assign lhs = value * `DFW_NEAR_DEN;
    assign rhs = max_value * `DFW_NEAR_NUM;
    assign near = (lhs >= rhs);
endmodule // dfw_near_limit

/* dfw_elapsed_time.v */
`timescale 1ns/10ps
`include "dfw_defines.vh"
// elapsed time indicator counters, seconds resolution
module dfw_elapsed_time #(
    parameter SECOND_CYCLES = `DFW_SECOND_CYCLES,
    parameter W = 32
) (
    clk,
    rstn,
    total_seed, // stored total powered seconds, loaded at start
    downs_seed, // stored power-down count, loaded at start
    enabled_seed, // stored total enabled seconds
    seed_load, // pulse: take the stored values
    enabled, // drive is enabled
    total_power_on_time,
    power_on_time_since_power_on,
    number_of_power_downs,
    enabled_time,
    enabled_time_since_power_on,
    enabled_time_since_enable
);
    input wire clk;
    input wire rstn;
    input wire [W-1:0] total_seed;
    input wire [W-1:0] downs_seed;
    input wire [W-1:0] enabled_seed;
    input wire seed_load;
    input wire enabled;
    output reg [W-1:0] total_power_on_time;
    output reg [W-1:0] power_on_time_since_power_on;
    output reg [W-1:0] number_of_power_downs;
    output reg [W-1:0] enabled_time;
    output reg [W-1:0] enabled_time_since_power_on;
    output reg [W-1:0] enabled_time_since_enable;
    reg [31:0] div; // cycles within the current second
    wire tick; // one-cycle pulse per second
    reg enabled_d; // previous enable, to see a fresh enable
    assign tick = (div == SECOND_CYCLES - 1);
    // second divider
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            div <= 32'h0;
        else if (tick)
            div <= 32'h0;
        else
            div <= div + 32'h1;
    end
    // counters; power-downs advance on seed load
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            total_power_on_time <= {W{1'b0}};
            power_on_time_since_power_on <= {W{1'b0}};
            number_of_power_downs <= {W{1'b0}};
            enabled_time <= {W{1'b0}};
            enabled_time_since_power_on <= {W{1'b0}};
            enabled_time_since_enable <= {W{1'b0}};
            enabled_d <= 1'b0;
        end
        else
        begin
            enabled_d <= enabled;
            if (seed_load)
            begin
                // a restart means the previous power cycle ended
                total_power_on_time <= total_seed;
                number_of_power_downs <= downs_seed + {{(W-1){1'b0}}, 1'b1};
                enabled_time <= enabled_seed;
            end
            else if (tick)
            begin
                total_power_on_time <= total_power_on_time + {{(W-1){1'b0}}, 1'b1};
                if (enabled)
                    enabled_time <= enabled_time + {{(W-1){1'b0}}, 1'b1};
            end
            if (tick)
                power_on_time_since_power_on <= power_on_time_since_power_on + {{(W-1){1'b0}}, 1'b1};
            if (tick && enabled)
                enabled_time_since_power_on <= enabled_time_since_power_on + {{(W-1){1'b0}}, 1'b1};
            // current enable time restarts at each new enable
            if (enabled && !enabled_d)
                enabled_time_since_enable <= {W{1'b0}};
            else if (tick && enabled)
                enabled_time_since_enable <= enabled_time_since_enable + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // dfw_elapsed_time

/* dfw_power_model.sv */
`timescale 1ns/10ps
// power section model
module dfw_power_model #(
    parameter int SOFT_CYCLES = 40 // charge time, short for a brief run
) (
    input logic clk,
    input logic rstn,
    input logic mains_on, // mains applied
    output logic hv_present, // bus voltage present
    output logic softstart_done // full power available
);
    int charge; // charge cycles so far
    // falling edge, like the stimulus, to avoid races
    always @(negedge clk or negedge rstn)
    begin
        if (!rstn)
            charge <= 0;
        else if (!mains_on)
            charge <= 0; // mains lost: soft-start reruns
        else if (charge < SOFT_CYCLES)
            charge <= charge + 1;
    end
    assign hv_present = mains_on && charge > 0;
    assign softstart_done = charge == SOFT_CYCLES;
endmodule // dfw_power_model

/* dfw_monitor_asserts.sv */
`timescale 1ns/10ps
// checks on the monitor's pins; outputs lag one clock
module dfw_monitor_asserts (
    input logic clk, rstn, hv_present, softstart_done, position_mode, position_error_over,
    input logic limit_cw, manual_mode, bridge_foldback, motor_foldback, ambient_foldback,
    input logic version_mismatch, power_stage_on, brake_request, drive_enabled, current_limited, block_cw,
    input logic [4:0] fault_code, display_code,
    input logic [1:0] display_kind,
    input logic [6:0] manual_pct,
    input logic [15:0] motor_temp, motor_temp_max, bridge_temp, bridge_temp_max, ambient_temp,
    input logic [15:0] ambient_temp_max, regen_power, regen_power_max, supply_mv, demand_abs, i2t_limit,
    input logic [15:0] current_limit_nom, velocity_limit_nom, current_limit, velocity_limit,
    input logic [17:0] warnings,
    input logic [31:0] it_integral, it_max
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // near test in 32 bits, no wrap
    function automatic logic nr(input logic [15:0] v, input logic [15:0] m);
        return {16'h0, v} * 32'hA >= {16'h0, m} * 32'h9;
    endfunction
    sequence s_rise;
        $rose(drive_enabled) && fault_code == 5'h00;
    endsequence
    sequence s_live;
        power_stage_on && !brake_request;
    endsequence
    property p_fault_halt;
        fault_code != 5'h00 |=> !power_stage_on && !drive_enabled && brake_request;
    endproperty
    a_fault_halt: assert property (p_fault_halt) else $error("fault kept power");
    property p_fault_show;
        fault_code != 5'h00 |=> display_kind == 2'h3 && display_code == $past(fault_code);
    endproperty
    a_fault_show: assert property (p_fault_show) else $error("fault not shown");
    property p_idle_show;
        display_kind < 2'h2 |-> display_code == {4'h0, display_kind[0]};
    endproperty
    a_idle_show: assert property (p_idle_show) else $error("idle code wrong");
    property p_engage;
        s_rise |=> s_live;
    endproperty
    a_engage: assert property (p_engage) else $error("enable unpowered");
    property p_limiting;
        bridge_foldback || motor_foldback || ambient_foldback || manual_mode |=> current_limited;
    endproperty
    a_limiting: assert property (p_limiting) else $error("limiting not indicated");
    property p_softstart;
        hv_present && !softstart_done |=> warnings[0] && !$rose(drive_enabled);
    endproperty
    a_softstart: assert property (p_softstart) else $error("no U1");
    property p_near;
        1 |=> {warnings[12], warnings[3:1]} == $past({nr(ambient_temp, ambient_temp_max),
            nr(regen_power, regen_power_max), nr(bridge_temp, bridge_temp_max), nr(motor_temp, motor_temp_max)});
    endproperty
    a_near: assert property (p_near) else $error("near-limit warning wrong");
    property p_level;
        1 |=> {warnings[11:9], warnings[6], warnings[4]} == $past({ambient_foldback, motor_foldback,
            bridge_foldback, supply_mv < 16'h4650 || supply_mv > 16'h7D00, position_mode && position_error_over});
    endproperty
    a_level: assert property (p_level) else $error("level warning wrong");
    property p_limit;
        limit_cw [*8] |=> block_cw && warnings[5];
    endproperty
    a_limit: assert property (p_limit) else $error("switch not blocking");
    property p_manual;
        manual_mode |=> warnings[7] && {16'h0, velocity_limit} == {16'h0, $past(velocity_limit_nom)}
            * $past(manual_pct) / 32'h64 && {16'h0, current_limit} == {16'h0, $past(current_limit_nom)}
            * $past(manual_pct) / 32'h64;
    endproperty
    a_manual: assert property (p_manual) else $error("manual caps wrong");
    property p_u9_hold;
        warnings[8] && !drive_enabled |=> warnings[8];
    endproperty
    a_u9_hold: assert property (p_u9_hold) else $error("U9 dropped");
    property p_version;
        version_mismatch |=> warnings[13] && !$rose(drive_enabled);
    endproperty
    a_version: assert property (p_version) else $error("mismatch not refused");
    property p_i2t;
        drive_enabled && demand_abs >= i2t_limit |=> warnings[16] && current_limited;
    endproperty
    a_i2t: assert property (p_i2t) else $error("no U17");
    property p_it;
        it_integral > it_max |=> warnings[17] && current_limited;
    endproperty
    a_it: assert property (p_it) else $error("no U18");
endmodule // dfw_monitor_asserts

/* drive_fault_warning_monitor_bench.sv */
`timescale 1ns/10ps
module drive_fault_warning_monitor_bench;
    typedef struct {int due; logic [1:0] kind; logic [4:0] code; logic [17:0] warn; logic [2:0] flags;
        logic [15:0] vlim;} dfw_note_t; // flags: power, brake, enabled
    logic clk = 1'b0, rstn = 1'b0, mains_on = 1'b1;
    logic hv_present, softstart_done; // from the power model
    logic logic_present = 1'b1, hw_enable = 1'b1, enable_req = 1'b0, position_mode = 1'b1, position_error_over = 1'b0;
    logic limit_cw = 1'b0, limit_ccw = 1'b0, manual_mode = 1'b0, bridge_foldback = 1'b0, motor_foldback = 1'b0;
    logic ambient_foldback = 1'b0, version_mismatch = 1'b0, eti_seed_load = 1'b0;
    logic [4:0] fault_code = 5'h0;
    logic [6:0] manual_pct;
    logic [15:0] bridge_temp = 16'h0, motor_temp = 16'h0, ambient_temp = 16'h0, regen_power = 16'h0;
    logic [15:0] bridge_temp_max, motor_temp_max, ambient_temp_max;
    logic [15:0] regen_power_max, supply_mv = 16'h5DC0, demand_abs = 16'h0, i2t_limit;
    logic [15:0] current_limit_nom = 16'h0800, velocity_limit_nom, current_limit, velocity_limit;
    logic [31:0] it_integral = 32'h0, it_max, eti_total_seed = 32'h0, eti_downs_seed = 32'h0;
    logic [31:0] eti_enabled_seed = 32'h0, downs_exp = 32'h0; // expected power-down count
    logic power_stage_on, brake_request, drive_enabled, current_limited, block_cw, block_ccw;
    logic [17:0] warnings;
    logic [1:0] display_kind;
    logic [4:0] display_code;
    logic [31:0] elapsed_time_indicator_total_power_on_time, elapsed_time_indicator_power_on_time_since_power_on;
    logic [31:0] elapsed_time_indicator_number_of_power_downs, elapsed_time_indicator_enabled_time;
    logic [31:0] elapsed_time_indicator_enabled_time_since_power_on, elapsed_time_indicator_enabled_time_since_enable;
    int cyc = 0, n_errors = 0, n_compared = 0, n; // n: warning in play
    dfw_note_t q[$], e; // pending expectations
    // 100 MHz clock
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    dfw_power_model u_pwr (.clk(clk), .rstn(rstn), .mains_on(mains_on), .hv_present(hv_present),
        .softstart_done(softstart_done));
    // short second for the counters
    dfw_monitor #(.SECOND_CYCLES(10)) u_dut (.*);
    function automatic logic [15:0] thr(input logic [15:0] m); // lowest reading counted as near
        return 16'(({16'h0, m} * 32'h9 + 32'h9) / 32'hA);
    endfunction
    task automatic wt(input int k);
        repeat (k) @(negedge clk);
    endtask
    // velocity expectation uses manual mode as now set
    task automatic note(input int d, input logic [1:0] k, input logic [4:0] c, input logic [17:0] w,
        input logic [2:0] f);
        q.push_back('{cyc + d, k, c, w, f, manual_mode ? 16'(({16'h0, velocity_limit_nom} * manual_pct) / 32'h64)
            : velocity_limit_nom});
    endtask
    // fresh enable edge: drop, then raise
    task automatic bid();
        enable_req = 1'b0;
        wt(8);
        enable_req = 1'b1;
        wt(10);
    endtask
    // one warning cause at its boundary; n = warning raised
    task automatic cond(input int i, input logic on);
        n = (i > 18) ? ((i == 21) ? 0 : i - 13) : i;
        case (i)
            2: motor_temp = thr(motor_temp_max) - 16'(!on);
            3: bridge_temp = thr(bridge_temp_max) - 16'(!on);
            4: regen_power = thr(regen_power_max) - 16'(!on);
            5: position_error_over = on;
            6: limit_cw = on;
            7: supply_mv = 16'h4650 - 16'(on);
            8: manual_mode = on;
            10: bridge_foldback = on;
            11: motor_foldback = on;
            12: ambient_foldback = on;
            13: ambient_temp = thr(ambient_temp_max) - 16'(!on);
            17: demand_abs = on ? i2t_limit : 16'($urandom_range(i2t_limit - 16'h1));
            18: it_integral = it_max + 32'(on);
            19: limit_ccw = on;
            20: supply_mv = 16'h7D00 + 16'(on);
            21: {position_mode, position_error_over} = {!on, on}; // error outside position mode
            default: n = -1;
        endcase
    endtask
    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // oldest due note against settled outputs
    always @(negedge clk)
    begin
        if (q.size() > 0 && q[0].due <= cyc)
        begin
            e = q.pop_front();
            n_compared++;
            if ({display_kind, display_code, warnings, power_stage_on, brake_request, drive_enabled, velocity_limit,
                elapsed_time_indicator_number_of_power_downs} !== {e.kind, e.code, e.warn, e.flags, e.vlim,
                downs_exp})
            begin
                n_errors++;
                $display("CHECK FAILED at %0t: shows %h/%h warn %h", $time, display_kind, display_code, warnings);
            end
        end
    end
    // tests take about 450 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(90638));
        motor_temp_max = 16'($urandom_range(16'hF000, 16'h0100));
        bridge_temp_max = 16'($urandom_range(16'hF000, 16'h0100));
        ambient_temp_max = 16'($urandom_range(16'hF000, 16'h0100));
        regen_power_max = 16'($urandom_range(16'hF000, 16'h0100));
        velocity_limit_nom = 16'($urandom);
        manual_pct = 7'($urandom_range(32'h64, 32'h1));
        i2t_limit = 16'($urandom_range(16'hF000, 16'h0100));
        it_max = $urandom_range(32'h7FFFFFFF);
        wt(8);
        rstn = 1'b1;
        eti_downs_seed = $urandom;
        downs_exp = eti_downs_seed + 32'h1;
        eti_seed_load = 1'b1;
        enable_req = 1'b1; // attempt while still in soft-start
        wt(1);
        eti_seed_load = 1'b0;
        wt(7);
        note(2, 2'h2, 5'h01, 18'h00101, 3'h2);
        while (!softstart_done && cyc < 200)
            wt(1);
        wt(2);
        note(2, 2'h2, 5'h09, 18'h00100, 3'h2);
        wt(3);
        bid();
        note(2, 2'h1, 5'h01, 18'h0, 3'h5);
        wt(3);
        for (int i = 2; i < 22; i++)
        begin
            cond(i, 1'b1);
            if (n >= 0)
            begin
                note(8, n ? 2'h2 : 2'h1, n ? 5'(n) : 5'h01, n ? 18'h1 << (n - 1) : 18'h0, 3'h5);
                wt(9);
                cond(i, 1'b0);
                note(8, 2'h1, 5'h01, 18'h0, 3'h5);
                wt(9);
            end
        end
        cond(13, 1'b1);
        cond(3, 1'b1);
        note(2, 2'h2, 5'h03, 18'h01004, 3'h5);
        wt(3);
        fault_code = 5'($urandom_range(32'h1B, 32'h1));
        note(2, 2'h3, fault_code, 18'h01004, 3'h2);
        wt(3);
        fault_code = 5'h00;
        cond(13, 1'b0);
        cond(3, 1'b0);
        note(2, 2'h0, 5'h00, 18'h0, 3'h2);
        wt(3);
        for (int r = 0; r < 2; r++)
        begin
            version_mismatch = (r == 0);
            hw_enable = (r == 0);
            bid();
            note(2, 2'h2, 5'h09, r ? 18'h00100 : 18'h02100, 3'h2);
            wt(3);
            version_mismatch = 1'b0;
            hw_enable = 1'b1;
            wt(3);
            note(2, 2'h2, 5'h09, 18'h00100, 3'h2);
            wt(3);
        end
        bid();
        note(2, 2'h1, 5'h01, 18'h0, 3'h5);
        wt(3);
        complete_run();
    end
endmodule // drive_fault_warning_monitor_bench
bind dfw_monitor dfw_monitor_asserts u_chk (.*);
